// file: core/scan_tap.sv
// test access port: state machine, instruction, bypass and data registers
//
// Notes on behaviour
// - entering instruction shift turns the serial output on at the falling edge; first bit enters at the next rise.
// - in instruction shift one bit enters the 8-bit instruction register per rising edge.
// - an instruction scan sends out the captured pattern 10000001, low end first, as new bits enter.
// - the last instruction bit shifts on the rise that moves instruction shift to its first exit state.
// - on the falling edge after either shift state is left the serial output goes high impedance.
// - instruction update loads the shifted value on the falling edge; all ones selects bypass.
// - with bypass active the bypass bit captures zero on the rise leaving data capture.
// - entering data shift turns the serial output on at the falling edge; first bit enters at the next rise.
// - in bypass the port is a one-stage delay, the captured zero leading the shifted bits.
// - data update moves shifted data into the selected register's parallel stage on the falling edge.
// - serial and mode inputs are sampled on rising edges; serial output changes only on falling edges.
`timescale 1ns/1ps
module scan_tap
	import scan_tap_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic [IR_W-1:0] ir_active_o,
	output logic [DR_W-1:0] dr_parallel_o
);

	tap_regs_s r_q;
	tap_regs_s r_d;

	// sixteen-state walk, advanced only by a rising test clock
	function automatic tap_state_e next_state(input tap_state_e s, input logic tms);
		tap_state_e n;
		n = s;
		// each state has two exits, picked by mode select at the rise
		case (s)
			// parked in reset while mode stays high
			TEST_LOGIC_RESET: begin
				if (tms) begin
					n = TEST_LOGIC_RESET;
				end else begin
					n = RUN_TEST_IDLE;
				end
			end
			// idle between scans
			RUN_TEST_IDLE: begin
				if (tms) begin
					n = SELECT_DR_SCAN;
				end else begin
					n = RUN_TEST_IDLE;
				end
			end
			// data scan, or move on towards instructions
			SELECT_DR_SCAN: begin
				if (tms) begin
					n = SELECT_IR_SCAN;
				end else begin
					n = CAPTURE_DR;
				end
			end
			// data register loaded; shift or leave early
			CAPTURE_DR: begin
				if (tms) begin
					n = EXIT1_DR;
				end else begin
					n = SHIFT_DR;
				end
			end
			// one data bit per rise until mode goes high
			SHIFT_DR: begin
				if (tms) begin
					n = EXIT1_DR;
				end else begin
					n = SHIFT_DR;
				end
			end
			// first data exit: update or pause
			EXIT1_DR: begin
				if (tms) begin
					n = UPDATE_DR;
				end else begin
					n = PAUSE_DR;
				end
			end
			// data scan held, register frozen
			PAUSE_DR: begin
				if (tms) begin
					n = EXIT2_DR;
				end else begin
					n = PAUSE_DR;
				end
			end
			// second data exit: update or resume shifting
			EXIT2_DR: begin
				if (tms) begin
					n = UPDATE_DR;
				end else begin
					n = SHIFT_DR;
				end
			end
			// data update, then another scan or idle
			UPDATE_DR: begin
				if (tms) begin
					n = SELECT_DR_SCAN;
				end else begin
					n = RUN_TEST_IDLE;
				end
			end
			// instruction scan, or fall back to reset
			SELECT_IR_SCAN: begin
				if (tms) begin
					n = TEST_LOGIC_RESET;
				end else begin
					n = CAPTURE_IR;
				end
			end
			// fixed pattern loaded; shift or leave early
			CAPTURE_IR: begin
				if (tms) begin
					n = EXIT1_IR;
				end else begin
					n = SHIFT_IR;
				end
			end
			// one instruction bit per rise until mode goes high
			SHIFT_IR: begin
				if (tms) begin
					n = EXIT1_IR;
				end else begin
					n = SHIFT_IR;
				end
			end
			// first instruction exit: update or pause
			EXIT1_IR: begin
				if (tms) begin
					n = UPDATE_IR;
				end else begin
					n = PAUSE_IR;
				end
			end
			// instruction scan held, register frozen
			PAUSE_IR: begin
				if (tms) begin
					n = EXIT2_IR;
				end else begin
					n = PAUSE_IR;
				end
			end
			// second instruction exit: update or resume shifting
			EXIT2_IR: begin
				if (tms) begin
					n = UPDATE_IR;
				end else begin
					n = SHIFT_IR;
				end
			end
			// instruction update, then a data scan or idle
			UPDATE_IR: begin
				if (tms) begin
					n = SELECT_DR_SCAN;
				end else begin
					n = RUN_TEST_IDLE;
				end
			end
			// unused codes recover through reset
			default: begin
				n = TEST_LOGIC_RESET;
			end
		endcase
		return n;
	endfunction

	// all next-state logic; edges of the test clock are found from the synchroniser
	always_comb begin
		logic stable;
		logic tck_rise;
		logic tck_fall;
		logic tms_s;
		logic tdi_s;
		logic is_bypass;
		stable = 1'b0;
		tck_rise = 1'b0;
		tck_fall = 1'b0;
		tms_s = 1'b0;
		tdi_s = 1'b0;
		is_bypass = 1'b0;
		r_d = r_q;

		// stage 0 feeds stage 1 only; stages 1 and 2 must agree before a change counts
		// a test clock phase under two system clocks may be lost, so each phase
		// of tck should last at least two system clocks
		r_d.sync[0] = '{tck: tck_i, tms: tms_i, tdi: tdi_i};
		r_d.sync[1] = r_q.sync[0];
		r_d.sync[2] = r_q.sync[1];
		stable = (r_q.sync[1].tck == r_q.sync[2].tck);
		tck_rise = stable && r_q.sync[2].tck && !r_q.tck_lvl;
		tck_fall = stable && !r_q.sync[2].tck && r_q.tck_lvl;
		if (stable) begin
			r_d.tck_lvl = r_q.sync[2].tck;
		end
		// pins travel the same depth as the clock, so they are the values at its edge
		tms_s = r_q.sync[2].tms;
		tdi_s = r_q.sync[2].tdi;
		// only the all-ones code selects bypass; any other picks the data register
		is_bypass = (r_q.ir_active == IR_BYPASS);

		// rising edge: sample inputs, capture and shift, advance the machine
		if (tck_rise) begin
			r_d.state = next_state(r_q.state, tms_s);
			case (r_q.state)
				CAPTURE_IR: begin
					r_d.ir_shift = IR_CAPTURE_VAL;
				end
				SHIFT_IR: begin
					// the bit shifts even on the rise into the exit state
					r_d.ir_shift = {tdi_s, r_q.ir_shift[IR_W-1:1]};
				end
				CAPTURE_DR: begin
					if (is_bypass) begin
						r_d.bypass_bit = BYPASS_CAPTURE_VAL;
					end else begin
						// other codes reload the shift stage from the parallel stage
						r_d.dr_shift = r_q.dr_parallel;
					end
				end
				SHIFT_DR: begin
					if (is_bypass) begin
						// one flip-flop deep, so each bit leaves one clock later
						r_d.bypass_bit = tdi_s;
					end else begin
						r_d.dr_shift = {tdi_s, r_q.dr_shift[DR_W-1:1]};
					end
				end
				default: begin
				end
			endcase
		end

		// falling edge: drive the serial output and update parallel stages
		if (tck_fall) begin
			case (r_q.state)
				SHIFT_IR: begin
					// low end leaves first, one bit per fall
					r_d.tdo_oe = 1'h1;
					r_d.tdo = r_q.ir_shift[0];
				end
				SHIFT_DR: begin
					r_d.tdo_oe = 1'b1;
					r_d.tdo = is_bypass ? r_q.bypass_bit : r_q.dr_shift[0];
				end
				UPDATE_IR: begin
					r_d.tdo_oe = 1'b0;
					// an all-ones code turns on bypass from this fall
					r_d.ir_active = r_q.ir_shift;
				end
				UPDATE_DR: begin
					r_d.tdo_oe = 1'b0;
					// bypass has no parallel stage, so the data register keeps its value
					if (!is_bypass) begin
						r_d.dr_parallel = r_q.dr_shift;
					end
				end
				TEST_LOGIC_RESET: begin
					// back to bypass so a stray scan cannot misfire
					r_d.tdo_oe = 1'h0;
					r_d.ir_active = IR_RESET_VAL;
				end
				default: begin
					r_d.tdo_oe = 1'b0;
				end
			endcase
		end
	end

	// single state register; reset leaves the port idle in test-logic-reset
	// tck level restarts low like the idle pin, so no false edge follows reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r_q <= '{
				sync: '0,
				tck_lvl: 1'b0,
				state: TEST_LOGIC_RESET,
				ir_shift: IR_RESET_VAL,
				ir_active: IR_RESET_VAL,
				bypass_bit: BYPASS_CAPTURE_VAL,
				dr_shift: DR_RESET_VAL,
				dr_parallel: DR_RESET_VAL,
				tdo: 1'b0,
				tdo_oe: 1'b0
			};
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register
	// tdo keeps its last level while disabled; the pad, not this block, floats it
	assign tdo_o = r_q.tdo;
	assign tdo_oe_o = r_q.tdo_oe;
	assign ir_active_o = r_q.ir_active;
	assign dr_parallel_o = r_q.dr_parallel;

endmodule

// file: core/scan_tap_pkg.sv
// shared types and constants for the scan test access port
package scan_tap_pkg;

	localparam int IR_W = 8;
	localparam int DR_W = 8;
	localparam int SYNC_W = 3;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h81;
	localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
	localparam logic [IR_W-1:0] IR_RESET_VAL = 8'hff;
	localparam logic [DR_W-1:0] DR_RESET_VAL = 8'h00;
	localparam logic BYPASS_CAPTURE_VAL = 1'b0;

	typedef enum logic [3:0] {
		TEST_LOGIC_RESET,
		RUN_TEST_IDLE,
		SELECT_DR_SCAN,
		CAPTURE_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPDATE_DR,
		SELECT_IR_SCAN,
		CAPTURE_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPDATE_IR
	} tap_state_e;

	// raw port pins as sampled by the system clock
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} pins_s;

	typedef struct packed {
		pins_s [SYNC_W-1:0] sync;
		logic tck_lvl;
		tap_state_e state;
		logic [IR_W-1:0] ir_shift;
		logic [IR_W-1:0] ir_active;
		logic bypass_bit;
		logic [DR_W-1:0] dr_shift;
		logic [DR_W-1:0] dr_parallel;
		logic tdo;
		logic tdo_oe;
	} tap_regs_s;

endpackage

// file: verif/scan_ctrl_model.sv
// boundary-scan controller model driving test clock, mode and serial input
`timescale 1ns/1ps
module scan_ctrl_model (
	input wire logic clk_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	// clock held low through reset, mode high keeps the port in reset
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// one 160 ns test clock; mode and data move only with the fall
	task automatic cycle(input logic m, input logic d);
		@(negedge clk_i);
		tck_o = 1'b0;
		tms_o = m;
		tdi_o = d;
		repeat (4) @(negedge clk_i);
		tck_o = 1'b1;
		repeat (3) @(negedge clk_i);
	endtask
endmodule

// file: verif/scan_tap_ir_bypass_sequencing_test.sv
// self-checking bench for the scan test access port
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h not %h", $time, a, b); end end
module scan_tap_ir_bypass_sequencing_test
	import scan_tap_pkg::*;
();
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, e;
	logic [IR_W-1:0] ir_active_o;
	logic [DR_W-1:0] dr_parallel_o;
	logic [7:0] v, a, b, r;
	logic exp_q[$];
	int error_cnt = 0;
	int check_count = 0;
	always #10 clk_i = ~clk_i;
	scan_ctrl_model scan_ctrl_model_inst (.clk_i(clk_i), .tck_o(tck_i), .tms_o(tms_i),
		.tdi_o(tdi_i));
	scan_tap scan_tap_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i),
		.tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ir_active_o(ir_active_o),
		.dr_parallel_o(dr_parallel_o));
	// tdo holds until the next fall, so judge it just as that fall arrives
	always @(negedge tck_i) begin
		if (tdo_oe_o === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
			`CHK(tdo_o, e)
		end
	end
	// from idle: capture, shift 8 bits of din noting dout, stop in update
	task automatic scan(input bit ir, input logic [7:0] din, input logic [7:0] dout);
		scan_ctrl_model_inst.cycle(1'b1, 1'($urandom));
		if (ir)
			scan_ctrl_model_inst.cycle(1'b1, 1'($urandom));
		repeat (2) scan_ctrl_model_inst.cycle(1'b0, 1'($urandom));
		for (int i = 0; i < 8; i++) begin
			exp_q.push_back(dout[i]);
			scan_ctrl_model_inst.cycle(i == 7, din[i]);
		end
		scan_ctrl_model_inst.cycle(1'b1, 1'($urandom));
	endtask
	task automatic stop_test();
		`CHK(exp_q.size(), 0)
		$display("checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(83));
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		scan_ctrl_model_inst.cycle(1'b0, 1'b0);
		scan(1'b1, IR_BYPASS, IR_CAPTURE_VAL);
		scan_ctrl_model_inst.cycle(1'b0, 1'b0);
		`CHK(ir_active_o, IR_BYPASS)
		$display("ir bypass test done");
		// top bit set leaves a one in the bypass stage, so the second capture must clear it
		repeat (2) begin
			r = 8'($urandom) | 8'h80;
			scan(1'b0, r, {r[6:0], BYPASS_CAPTURE_VAL});
		end
		scan_ctrl_model_inst.cycle(1'b0, 1'b0);
		`CHK(dr_parallel_o, DR_RESET_VAL)
		$display("bypass data test done");
		v = 8'($urandom) & 8'hfe;
		a = 8'($urandom);
		b = 8'($urandom);
		scan(1'b1, v, IR_CAPTURE_VAL);
		scan_ctrl_model_inst.cycle(1'b0, 1'b0);
		`CHK(ir_active_o, v)
		scan(1'b0, a, DR_RESET_VAL);
		scan_ctrl_model_inst.cycle(1'b0, 1'b0);
		`CHK(dr_parallel_o, a)
		scan(1'b0, b, a);
		repeat (4) scan_ctrl_model_inst.cycle(1'b1, 1'b0);
		`CHK(dr_parallel_o, b)
		`CHK(ir_active_o, IR_RESET_VAL)
		$display("data register test done");
		stop_test();
	end
	// about 14 us of traffic expected
	initial begin
		#50000;
		error_cnt++;
		stop_test();
	end
endmodule

// file: verif/scan_tap_properties.sv
// concurrent checks on the scan port outputs
`timescale 1ns/1ps
module scan_tap_properties
	import scan_tap_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic [IR_W-1:0] ir_active_o,
	input wire logic [DR_W-1:0] dr_parallel_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// pin fall lands some clocks before any output move, so look back past the sync delay
	a_tdo_on_fall: assert property (($changed(tdo_o) || $changed(tdo_oe_o)) |->
		$past(tck_i, 6) && !$past(tck_i, 2)) else $error("tdo moved off a fall");
	a_oe_holds: assert property ($rose(tdo_oe_o) |-> tdo_oe_o [*8])
		else $error("oe dropped early");
	a_oe_off_holds: assert property ($fell(tdo_oe_o) |-> !tdo_oe_o [*8])
		else $error("oe back too soon");
	a_tdo_steady: assert property ($changed(tdo_o) |=> $stable(tdo_o) [*6])
		else $error("tdo changed twice in a cycle");
	a_ir_on_fall: assert property ($changed(ir_active_o) |->
		$past(tck_i, 6) && !$past(tck_i, 2)) else $error("ir moved off a fall");
	a_dr_on_fall: assert property ($changed(dr_parallel_o) |->
		$past(tck_i, 6) && !$past(tck_i, 2)) else $error("dr moved off a fall");
	a_dr_update_quiet: assert property ($changed(dr_parallel_o) |->
		$stable(ir_active_o) && !tdo_oe_o) else $error("dr update not in update state");
	a_reset_values: assert property ($fell(sys_rst_i) |-> ir_active_o == IR_RESET_VAL &&
		dr_parallel_o == DR_RESET_VAL && !tdo_oe_o) else $error("bad reset values");
endmodule

bind scan_tap scan_tap_properties scan_tap_properties_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
	.tdo_oe_o(tdo_oe_o), .ir_active_o(ir_active_o), .dr_parallel_o(dr_parallel_o));
